// ===== rtl/fagc_pkg.sv
// shared constants and types for the filter and agc configuration block
package fagc_pkg;

	// register byte offsets on the apb bus
	localparam logic [11:0] FILTER_OFS = 12'h000;
	localparam logic [11:0] AGC_OFS    = 12'h004;
	localparam logic [11:0] STATUS_OFS = 12'h008;
	localparam logic [11:0] ERROR_OFS  = 12'h00C;

	// writable bits; reserved bits are dropped on write and read as zero
	localparam logic [31:0] FILTER_WMASK = 32'h003F_FFFF;
	localparam logic [31:0] AGC_WMASK    = 32'h3FFF_FFFF;

	// reset: halfbands bypassed, fir decimate by one, one tap
	localparam logic [31:0] FILTER_RESET = 32'h0010_0801;
	localparam logic [31:0] AGC_RESET    = 32'h0000_0000;

	localparam int          HB_STAGES  = 5;
	localparam logic [4:0]  DECIM_FULL = 5'h10;
	localparam logic [3:0]  PHASE_ZERO = 4'h0;
	localparam logic [3:0]  PHASE_STEP = 4'h1;

	// magnitude times 1.6, formed as 1 + 1/2 + 1/16 + 1/32
	localparam int MAG_SH_A = 1;
	localparam int MAG_SH_B = 4;
	localparam int MAG_SH_C = 5;

	// first control word, bit 31 down to bit 0
	typedef struct packed {
		logic [9:0] rsvd;
		logic       sync_en;
		logic       hb_bypass;
		logic [4:0] hb_en;         // bit 0 is stage one
		logic [3:0] fir_decim;
		logic       fir_dual_real;
		logic       fir_even_sym;
		logic       fir_asym;
		logic [7:0] fir_taps;
	} filter_word_t;

	typedef struct packed {
		logic [3:0] mant;          // loop_gain_mantissa, value / 16
		logic [3:0] expo;
	} loop_gain_t;

	// second control word, bit 31 down to bit 0
	typedef struct packed {
		logic [1:0]  rsvd;
		logic        sync_en;
		logic [12:0] threshold;    // signed, lsb weighs 2^-10
		loop_gain_t  gain1;
		loop_gain_t  gain0;
	} agc_word_t;

	// read-only status word
	typedef struct packed {
		logic [8:0] rsvd;
		logic [4:0] hb_last;
		logic       hb_cfg_bad;
		logic       taps_bad;
		logic [4:0] rsvd2;
		logic [2:0] hb_count;
		logic [2:0] rsvd3;
		logic [4:0] fir_decim;
	} status_word_t;

endpackage

// ===== rtl/fir_decim_phase.sv
// fir decimation phase counter with sync reset of its sequencing
`timescale 1ns/1ps
`default_nettype none

module fir_decim_phase (
	input  wire logic       clk,           // processing clock
	input  wire logic       rst_n,         // async reset, active low
	input  wire logic       seq_reset,     // sync restart of sequencing
	input  wire logic       sample_valid,  // one input sample this cycle
	input  wire logic [3:0] decim_field,   // raw field, zero means 16
	output logic      [3:0] phase_q,       // samples taken this period
	output logic            out_strobe_q   // one pulse per output sample
);

	// field minus one wraps 0000 to 1111, so zero gives sixteen
	logic [3:0] terminal;
	assign terminal = decim_field - fagc_pkg::PHASE_STEP;

	// count samples, emit a strobe on the last of each period
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q      <= 4'h0;
			out_strobe_q <= 1'b0;
		end else if (seq_reset) begin
			phase_q      <= fagc_pkg::PHASE_ZERO;
			out_strobe_q <= 1'b0;
		end else if (sample_valid && phase_q == terminal) begin
			phase_q      <= fagc_pkg::PHASE_ZERO;
			out_strobe_q <= 1'b1;
		end else begin
			phase_q      <= sample_valid ? phase_q + fagc_pkg::PHASE_STEP
			                             : phase_q;
			out_strobe_q <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ===== rtl/agc_step_calc.sv
// agc gain error and per-sample gain step, two register stages
`timescale 1ns/1ps
`default_nettype none

module agc_step_calc (
	input  wire logic                 clk,             // processing clock
	input  wire logic                 rst_n,           // async reset
	input  wire logic [12:0]          threshold,       // signed threshold
	input  wire logic [11:0]          magnitude,       // unsigned, lsb 2^-10
	input  wire logic                 magnitude_valid, // new magnitude
	input  wire fagc_pkg::loop_gain_t gain,            // selected gain set
	output logic signed [14:0]        gain_error_q,    // lsb 2^-10
	output logic signed [34:0]        gain_step_q,     // lsb 2^-29 of 1.5dB
	output logic                      step_valid_q     // step is fresh
);

	logic [13:0]        mag_ext;
	logic [13:0]        mag_scaled;
	logic signed [14:0] err_d;
	logic signed [19:0] prod;
	logic [3:0]         expo_q;
	logic [3:0]         mant_q;
	logic               err_valid_q;

	// magnitude times 1.6 then taken from the threshold
	assign mag_ext    = {2'h0, magnitude};
	assign mag_scaled = mag_ext + (mag_ext >> fagc_pkg::MAG_SH_A)
	                  + (mag_ext >> fagc_pkg::MAG_SH_B)
	                  + (mag_ext >> fagc_pkg::MAG_SH_C);
	assign err_d = $signed({{2{threshold[12]}}, threshold})
	             - $signed({1'b0, mag_scaled});

	// mantissa as a fraction of 16 kept in the lsb weight, exponent
	// shifts left so the 2^-15 bias lives in the output lsb
	// both factors widened first so the product is not cut at 15 bits
	assign prod = 20'(gain_error_q)
	            * 20'($signed({1'b0, mant_q}));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gain_error_q <= 15'sh0000;
			mant_q       <= 4'h0;
			expo_q       <= 4'h0;
			err_valid_q  <= 1'b0;
			gain_step_q  <= 35'sh0;
			step_valid_q <= 1'b0;
		end else begin
			if (magnitude_valid) begin
				gain_error_q <= err_d;
				mant_q       <= gain.mant;
				expo_q       <= gain.expo;
			end
			err_valid_q  <= magnitude_valid;
			if (err_valid_q) begin
				gain_step_q <= $signed({{15{prod[19]}}, prod}) <<< expo_q;
			end
			step_valid_q <= err_valid_q;
		end
	end

endmodule
`default_nettype wire

// ===== rtl/filter_agc_config.sv
// apb register bank that configures the halfband, fir and agc chain
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module filter_agc_config (
	input  wire logic         pclk,                // processing clock
	input  wire logic         presetn,             // async reset, low
	input  wire logic         psel,                // apb select
	input  wire logic         penable,             // apb access phase
	input  wire logic         pwrite,              // apb direction
	input  wire logic [11:0]  paddr,               // apb byte address
	input  wire logic [31:0]  pwdata,              // apb write data
	output logic      [31:0]  prdata,              // apb read data
	output logic              pready,              // apb ready
	output logic              pslverr,             // apb error
	input  wire logic         filter_sync_input,   // external sync
	input  wire logic         agc_gain_set_select, // loop gain set pick
	input  wire logic         sample_valid,        // fir input sample
	input  wire logic [11:0]  magnitude,           // polar magnitude
	input  wire logic         magnitude_valid,     // magnitude strobe
	output logic      [4:0]   hb_path_en,          // stage in path
	output logic              hb_bypass,           // route around all
	output logic      [4:0]   hb_last_stage,       // one-hot exit stage
	output logic      [2:0]   hb_decim_log2,       // halfband rate log2
	output logic      [4:0]   fir_decim,           // 1..16
	output logic              fir_dual_real,       // two real filters
	output logic              fir_even_sym,        // even symmetry
	output logic              fir_asym,            // asymmetric
	output logic      [7:0]   fir_taps,            // tap count
	output logic              filter_ctl_reset,    // sequencing reset
	output logic      [3:0]   fir_phase,           // decimation phase
	output logic              fir_out_strobe,      // fir output slot
	output logic              agc_load,            // load accumulator
	output logic      [12:0]  agc_threshold,       // threshold field
	output logic signed [14:0] agc_gain_error,     // gain error
	output logic signed [34:0] agc_gain_step,      // gain per sample
	output logic              agc_step_valid       // step fresh
);

	// both words sit on pclk, the processing clock
	fagc_pkg::filter_word_t filter_q;
	fagc_pkg::agc_word_t    agc_q;
	fagc_pkg::status_word_t status;
	fagc_pkg::loop_gain_t   gain_sel;

	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [4:0]  hb_path_en_q;
	logic        hb_bypass_q;
	logic [4:0]  hb_last_q;
	logic [2:0]  hb_count_q;
	logic [4:0]  fir_decim_q;
	logic        fir_dual_real_q;
	logic        fir_even_sym_q;
	logic        fir_asym_q;
	logic [7:0]  fir_taps_q;
	logic        filter_ctl_reset_q;
	logic        agc_load_q;
	logic [12:0] agc_threshold_q;

	// bus decode
	logic        hit_filter;
	logic        hit_agc;
	logic        hit_status;
	logic        hit_error;
	logic        addr_hit;
	logic        setup_phase;
	logic        wr_commit;
	logic [31:0] rd_data;

	// halfband and fir decode
	logic [4:0]  hb_sel;
	logic [4:0]  hb_last;
	logic [2:0]  hb_count;
	logic [4:0]  decim_value;
	logic        taps_bad;
	logic        hb_cfg_bad;

	// apb address decode, unmapped offsets give pslverr
	assign hit_filter  = paddr == fagc_pkg::FILTER_OFS;
	assign hit_agc     = paddr == fagc_pkg::AGC_OFS;
	assign hit_status  = paddr == fagc_pkg::STATUS_OFS;
	assign hit_error   = paddr == fagc_pkg::ERROR_OFS;
	assign addr_hit    = hit_filter | hit_agc | hit_status | hit_error;
	assign setup_phase = psel & ~penable;
	assign wr_commit   = psel & penable & pready_q & pwrite;

	// read mux, captured one edge early so data is a flop
	assign rd_data = hit_filter ? filter_q :
	                 hit_agc    ? agc_q :
	                 hit_status ? status :
	                 hit_error  ? {{17{agc_gain_error[14]}}, agc_gain_error} :
	                              32'h0000_0000;

	// bypass clears the path, else the per-stage enables
	assign hb_sel = filter_q.hb_bypass ? 5'h00 : filter_q.hb_en;

	// exit stage: highest enabled stage with none enabled above it
	genvar i;
	generate
		for (i = 0; i < fagc_pkg::HB_STAGES; i++) begin : g_last
			if (i == fagc_pkg::HB_STAGES - 1) begin : g_top
				assign hb_last[i] = hb_sel[i];
			end else begin : g_mid
				assign hb_last[i] = hb_sel[i] &
				                    ~|hb_sel[fagc_pkg::HB_STAGES-1:i+1];
			end
		end
	endgenerate

	// each stage in the path halves the rate, the rest pass through
	assign hb_count = 3'({2'h0, hb_sel[0]}) + 3'({2'h0, hb_sel[1]})
	                + 3'({2'h0, hb_sel[2]}) + 3'({2'h0, hb_sel[3]})
	                + 3'({2'h0, hb_sel[4]});

	// zero in the field means sixteen
	assign decim_value = (filter_q.fir_decim == 4'h0) ? fagc_pkg::DECIM_FULL
	                                                 : {1'b0, filter_q.fir_decim};

	// host misuse is flagged, never repaired: zero taps and
	// no stage left while not bypassed
	assign taps_bad   = filter_q.fir_taps == 8'h00;
	assign hb_cfg_bad = ~filter_q.hb_bypass & (filter_q.hb_en == 5'h00);

	// status word shows the decoded configuration
	always_comb begin
		status            = '0;
		status.fir_decim  = decim_value;
		status.hb_count   = hb_count;
		status.taps_bad   = taps_bad;
		status.hb_cfg_bad = hb_cfg_bad;
		status.hb_last    = hb_last;
	end

	// loop gain set chosen by the select input
	assign gain_sel = agc_gain_set_select ? agc_q.gain1 : agc_q.gain0;

	// apb handshake: one wait-free access phase after each setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= setup_phase;
			pslverr_q <= setup_phase & ~addr_hit;
			if (setup_phase) begin
				prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
			end
		end
	end

	// control word writes; reserved bits never stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filter_q <= fagc_pkg::FILTER_RESET;
			agc_q    <= fagc_pkg::AGC_RESET;
		end else if (wr_commit) begin
			if (hit_filter) begin
				filter_q <= pwdata & fagc_pkg::FILTER_WMASK;
			end
			if (hit_agc) begin
				agc_q <= pwdata & fagc_pkg::AGC_WMASK;
			end
		end
	end

	// decoded filter controls, registered toward the chain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hb_path_en_q    <= 5'h00;
			hb_bypass_q     <= 1'b1;
			hb_last_q       <= 5'h00;
			hb_count_q      <= 3'h0;
			fir_decim_q     <= 5'h01;
			fir_dual_real_q <= 1'b0;
			fir_even_sym_q  <= 1'b0;
			fir_asym_q      <= 1'b0;
			fir_taps_q      <= 8'h01;
		end else begin
			hb_path_en_q    <= hb_sel;
			hb_bypass_q     <= filter_q.hb_bypass;
			hb_last_q       <= hb_last;
			hb_count_q      <= hb_count;
			fir_decim_q     <= decim_value;
			fir_dual_real_q <= filter_q.fir_dual_real;
			fir_even_sym_q  <= filter_q.fir_even_sym;
			fir_asym_q      <= filter_q.fir_asym;
			fir_taps_q      <= filter_q.fir_taps;
		end
	end

	// sync is a level each cycle it is high; gated by the enable bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filter_ctl_reset_q <= 1'b0;
			agc_load_q         <= 1'b0;
			agc_threshold_q    <= 13'h0000;
		end else begin
			filter_ctl_reset_q <= filter_q.sync_en & filter_sync_input;
			agc_load_q         <= agc_q.sync_en & filter_sync_input;
			agc_threshold_q    <= agc_q.threshold;
		end
	end

	// fir sequencing restarts on the gated sync
	fir_decim_phase u_phase (
		.clk          (pclk),
		.rst_n        (presetn),
		.seq_reset    (filter_ctl_reset_q),
		.sample_valid (sample_valid),
		.decim_field  (filter_q.fir_decim),
		.phase_q      (fir_phase),
		.out_strobe_q (fir_out_strobe)
	);

	// error and step: threshold less 1.6 times magnitude, scaled by
	// mantissa/16 and 2^(exp-15)
	agc_step_calc u_step (
		.clk             (pclk),
		.rst_n           (presetn),
		.threshold       (agc_q.threshold),
		.magnitude       (magnitude),
		.magnitude_valid (magnitude_valid),
		.gain            (gain_sel),
		.gain_error_q    (agc_gain_error),
		.gain_step_q     (agc_gain_step),
		.step_valid_q    (agc_step_valid)
	);

	// outputs straight from flops
	assign prdata           = prdata_q;
	assign pready           = pready_q;
	assign pslverr          = pslverr_q;
	assign hb_path_en       = hb_path_en_q;
	assign hb_bypass        = hb_bypass_q;
	assign hb_last_stage    = hb_last_q;
	assign hb_decim_log2    = hb_count_q;
	assign fir_decim        = fir_decim_q;
	assign fir_dual_real    = fir_dual_real_q;
	assign fir_even_sym     = fir_even_sym_q;
	assign fir_asym         = fir_asym_q;
	assign fir_taps         = fir_taps_q;
	assign filter_ctl_reset = filter_ctl_reset_q;
	assign agc_load         = agc_load_q;
	assign agc_threshold    = agc_threshold_q;

endmodule
`default_nettype wire

// ===== tb/filter_agc_config_chk.sv
// port-level assertions for the filter and agc configuration block
`timescale 1ns/1ps
`default_nettype none

module filter_agc_config_chk (
	input wire logic               pclk,              // clock
	input wire logic               presetn,           // reset, low
	input wire logic               psel,              // apb select
	input wire logic               penable,           // apb access
	input wire logic               pready,            // apb ready
	input wire logic               pslverr,           // apb error
	input wire logic               filter_sync_input, // sync in
	input wire logic        [11:0] magnitude,         // magnitude
	input wire logic               magnitude_valid,   // magnitude strobe
	input wire logic        [4:0]  hb_path_en,        // stages in path
	input wire logic               hb_bypass,         // bypass
	input wire logic        [2:0]  hb_decim_log2,     // stage count
	input wire logic        [4:0]  fir_decim,         // fir decimation
	input wire logic               filter_ctl_reset,  // sequencing reset
	input wire logic        [3:0]  fir_phase,         // fir phase
	input wire logic               fir_out_strobe,    // fir slot
	input wire logic               agc_load,          // agc load
	input wire logic        [12:0] agc_threshold,     // threshold
	input wire logic signed [14:0] agc_gain_error,    // gain error
	input wire logic               agc_step_valid     // step fresh
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// threshold minus 1.6 times magnitude, shift-add form
	logic        [14:0] mag_scaled;
	logic signed [14:0] err_exp;
	assign mag_scaled = {3'h0, magnitude} + {4'h0, magnitude[11:1]}
		+ {7'h00, magnitude[11:4]} + {8'h00, magnitude[11:5]};
	assign err_exp = {{2{agc_threshold[12]}}, agc_threshold} - mag_scaled;

	// apb answer: one access cycle, never a held ready
	chk_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_bypass_empty: assert property (hb_bypass |->
		hb_path_en == 5'h00 && hb_decim_log2 == 3'h0)
		else $error("stage in path while bypassed");
	chk_stage_count: assert property (!hb_bypass |->
		hb_decim_log2 == $countones(hb_path_en))
		else $error("stage count mismatch");
	chk_decim_range: assert property (fir_decim >= 5'h01 && fir_decim <= 5'h10)
		else $error("fir decimation out of range");
	chk_sync_gate: assert property (!filter_sync_input |=>
		!filter_ctl_reset && !agc_load)
		else $error("sync effect without sync input");
	chk_phase_clear: assert property (filter_ctl_reset |=> fir_phase == 4'h0)
		else $error("phase not cleared by sync");
	chk_strobe_wrap: assert property (fir_out_strobe |-> fir_phase == 4'h0)
		else $error("phase not wrapped at strobe");
	chk_error_calc: assert property (magnitude_valid |=>
		agc_gain_error == $past(err_exp))
		else $error("gain error wrong");
	chk_step_timing: assert property (magnitude_valid |-> ##2 agc_step_valid)
		else $error("step not fresh two cycles on");
endmodule

`default_nettype wire

// ===== tb/filter_agc_config_bench.sv
// self-checking bench for the filter and agc configuration block
`timescale 1ns/1ps
`default_nettype none

module filter_agc_config_bench;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        [11:0] paddr, magnitude;
	logic        [31:0] pwdata, prdata, rd;
	logic               filter_sync_input, agc_gain_set_select, sample_valid;
	logic               magnitude_valid, hb_bypass, fir_dual_real, fir_even_sym;
	logic               fir_asym, filter_ctl_reset, fir_out_strobe, agc_load;
	logic               agc_step_valid, er;
	logic        [4:0]  hb_path_en, hb_last_stage, fir_decim;
	logic        [2:0]  hb_decim_log2;
	logic        [7:0]  fir_taps;
	logic        [3:0]  fir_phase;
	logic        [12:0] agc_threshold;
	logic signed [14:0] agc_gain_error;
	logic signed [34:0] agc_gain_step;
	int                 err_total, n_checks, cyc;

	filter_agc_config dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.filter_sync_input(filter_sync_input),
		.agc_gain_set_select(agc_gain_set_select), .sample_valid(sample_valid),
		.magnitude(magnitude), .magnitude_valid(magnitude_valid),
		.hb_path_en(hb_path_en), .hb_bypass(hb_bypass),
		.hb_last_stage(hb_last_stage), .hb_decim_log2(hb_decim_log2),
		.fir_decim(fir_decim), .fir_dual_real(fir_dual_real),
		.fir_even_sym(fir_even_sym), .fir_asym(fir_asym), .fir_taps(fir_taps),
		.filter_ctl_reset(filter_ctl_reset), .fir_phase(fir_phase),
		.fir_out_strobe(fir_out_strobe), .agc_load(agc_load),
		.agc_threshold(agc_threshold), .agc_gain_error(agc_gain_error),
		.agc_gain_step(agc_gain_step), .agc_step_valid(agc_step_valid));

	// 40 MHz processing clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// hang guard, far above the hundred or so cycles the tests need
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			$display("BAD %0t timeout", $time);
			complete_run();
		end
	end

	task automatic chk(input string what, input logic [63:0] got,
		input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %0h want %0h", $time, what, got, exp);
		end
	endtask

	// one apb transfer; request held until ready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		// slave answers in the first access cycle; a hang ends in timeout
		chk("ready wait", 64'(n), 64'd1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// write a filter word, read it back, check the decoded outputs
	task automatic filt(input logic [31:0] w, input logic [4:0] path,
		input logic [4:0] last, input logic [2:0] lg, input logic [4:0] dec);
		apb(1'b1, fagc_pkg::FILTER_OFS, w);
		apb(1'b0, fagc_pkg::FILTER_OFS, 32'h0000_0000);
		chk("filter readback", rd, w & 32'h003F_FFFF);
		#1;
		chk("bypass", hb_bypass, w[20]);
		chk("path", hb_path_en, path);
		if (!w[20]) chk("exit stage", hb_last_stage, last);
		chk("stages", hb_decim_log2, lg);
		chk("decim", fir_decim, dec);
		chk("dual real", fir_dual_real, w[10]);
		chk("even sym", fir_even_sym, w[9]);
		chk("asym", fir_asym, w[8]);
		chk("taps", fir_taps, w[7:0]);
	endtask

	// sync held two cycles, effect looked at one edge later
	task automatic sync_pulse(input logic ef, input logic ea);
		@(posedge pclk);
		filter_sync_input <= 1'b1;
		@(posedge pclk);
		#1;
		chk("filter reset", filter_ctl_reset, ef);
		chk("agc load", agc_load, ea);
		@(posedge pclk);
		filter_sync_input <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	// one magnitude; error after one edge, step after two
	task automatic agc_run(input logic sel, input logic [11:0] m,
		input logic [12:0] t, input logic [3:0] mt, input logic [3:0] ex);
		longint e;
		e = longint'($signed(t)) - m - (m >> 1) - (m >> 4) - (m >> 5);
		@(posedge pclk);
		agc_gain_set_select <= sel;
		magnitude <= m;
		magnitude_valid <= 1'b1;
		@(posedge pclk);
		magnitude_valid <= 1'b0;
		#1;
		chk("gain error", 64'(agc_gain_error), e);
		@(posedge pclk);
		#1;
		chk("step valid", agc_step_valid, 1'b1);
		chk("gain step", 64'(agc_gain_step), e * mt * (64'h1 << ex));
	endtask

	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, filter_sync_input} = 5'h00;
		{agc_gain_set_select, sample_valid, magnitude_valid} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		magnitude = 12'h000;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, fagc_pkg::FILTER_OFS, 32'h0000_0000);
		chk("filter reset word", rd, 32'h0010_0801);
		apb(1'b0, fagc_pkg::AGC_OFS, 32'h0000_0000);
		chk("agc reset word", rd, 32'h0000_0000);
		$display("test reset done");
		filt(32'hFFCA_85FF, 5'h15, 5'h10, 3'h3, 5'h10);
		filt(32'h001F_FA01, 5'h00, 5'h00, 3'h0, 5'h0F);
		filt(32'h0000_8810, 5'h01, 5'h01, 3'h1, 5'h01);
		$display("test filter word done");
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk("unmapped error", er, 1'b1);
		apb(1'b1, fagc_pkg::STATUS_OFS, 32'hFFFF_FFFF);
		chk("status write", er, 1'b0);
		apb(1'b0, fagc_pkg::FILTER_OFS, 32'h0000_0000);
		chk("word kept", rd, 32'h0000_8810);
		$display("test address map done");
		apb(1'b1, fagc_pkg::FILTER_OFS, 32'h0010_1001);
		sync_pulse(1'b0, 1'b0);
		apb(1'b1, fagc_pkg::FILTER_OFS, 32'h0030_1001);
		// one sample leaves the phase mid-period, so the sync has work
		@(posedge pclk);
		sample_valid <= 1'b1;
		@(posedge pclk);
		sample_valid <= 1'b0;
		#1;
		chk("phase one", fir_phase, 4'h1);
		sync_pulse(1'b1, 1'b0);
		#1;
		chk("phase cleared", fir_phase, 4'h0);
		@(posedge pclk);
		sample_valid <= 1'b1;
		repeat (2) @(posedge pclk);
		sample_valid <= 1'b0;
		#1;
		chk("fir strobe", fir_out_strobe, 1'b1);
		$display("test sync and phase done");
		apb(1'b1, fagc_pkg::AGC_OFS, 32'hEC00_FF10);
		apb(1'b0, fagc_pkg::AGC_OFS, 32'h0000_0000);
		chk("agc readback", rd, 32'h2C00_FF10);
		#1;
		chk("threshold", agc_threshold, 13'h0C00);
		sync_pulse(1'b1, 1'b1);
		agc_run(1'b1, 12'h5A8, 13'h0C00, 4'hF, 4'hF);
		agc_run(1'b0, 12'h000, 13'h0C00, 4'h1, 4'h0);
		agc_run(1'b0, 12'h5A8, 13'h0C00, 4'h1, 4'h0);
		apb(1'b1, fagc_pkg::AGC_OFS, 32'h1000_00A3);
		sync_pulse(1'b1, 1'b0);
		agc_run(1'b0, 12'h5A8, 13'h1000, 4'hA, 4'h3);
		agc_run(1'b1, 12'h100, 13'h1000, 4'h0, 4'h0);
		$display("test agc done");
		complete_run();
	end
endmodule

bind filter_agc_config filter_agc_config_chk u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .filter_sync_input(filter_sync_input),
	.magnitude(magnitude), .magnitude_valid(magnitude_valid),
	.hb_path_en(hb_path_en), .hb_bypass(hb_bypass),
	.hb_decim_log2(hb_decim_log2), .fir_decim(fir_decim),
	.filter_ctl_reset(filter_ctl_reset), .fir_phase(fir_phase),
	.fir_out_strobe(fir_out_strobe), .agc_load(agc_load),
	.agc_threshold(agc_threshold), .agc_gain_error(agc_gain_error),
	.agc_step_valid(agc_step_valid));

`default_nettype wire
